/* File: common/regfile_pkg.sv */
// Package with the sizes, ports and carriers of the multiport register file.
package regfile_pkg;

  localparam int WORDS     = 8;
  localparam int BITS      = 2;
  localparam int ADDR_W    = 3;
  localparam logic [BITS-1:0] STORE_RESET = 2'h0;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [BITS-1:0]   word_t;

  // One read port request: address and active-low output gate.
  typedef struct packed {
    addr_t addr;
    logic  read_gate_allow_n;
  } read_req_s;

  // Write port request: shared address, data and per-bit active-low enables.
  typedef struct packed {
    addr_t addr;
    word_t data;
    word_t bit_write_n;
  } write_req_s;

endpackage

/* File: rtl/three_port_reg_file.sv */
// Eight by two multiport register file with one write and two read ports.
//
// Functional notes
// - Eight two-bit words, held as two banks of eight bit cells.
// - Two reads and one write can happen in the same cycle.
// - Write destination comes only from the write address.
// - Each bit has its own write enable.
// - Writes take place on the rising clock edge.
// - While clock is low, a bit is written if its enable is low or has a rising edge; otherwise it holds.
// - While clock is low, a rising enable edge writes that bit.
// - While clock is high, each read port shows its addressed word.
// - Reads return the word written in the preceding half period.
// - On falling clock, each read port captures its word into a slave.
// - While clock is low, read address changes do not affect outputs.
// - Output gates enable the read data at any time.
`timescale 1ns/1ps
`default_nettype none

module three_port_reg_file
  import regfile_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Write port.
  input  wire write_req_s wr,
  // Read ports.
  input  wire read_req_s  rd_zero,
  input  wire read_req_s  rd_one,
  output logic [BITS-1:0] read_port_zero_out,
  output logic [BITS-1:0] read_port_one_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Storage.
  logic [WORDS-1:0] bank [BITS];
  logic [WORDS-1:0] next_bank [BITS];

  // Phase and enable history.
  logic             phase_high;
  logic             next_phase_high;
  word_t            enable_prev;
  word_t            next_enable_prev;

  // Write selection.
  logic [WORDS-1:0] word_hit;
  word_t            level_strobe;
  word_t            edge_strobe;
  word_t            write_strobe;

  // Read port zero.
  word_t            live_zero;
  word_t            slave_zero;
  word_t            next_slave_zero;
  word_t            held_zero;
  word_t            gated_zero;

  // Read port one.
  word_t            live_one;
  word_t            slave_one;
  word_t            next_slave_one;
  word_t            held_one;
  word_t            gated_one;
  logic             capture;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // One-hot select of a word from its address.
  function automatic logic [WORDS-1:0] decode_word(input addr_t a);
    logic [WORDS-1:0] hot;
    hot = '0;
    for (int w = 0; w < WORDS; w++) begin
      if (a == addr_t'(w)) begin
        hot[w] = 1'b1;
      end
    end
    return hot;
  endfunction

  // Level write: enable low while the phase is low.
  function automatic logic level_write(input logic phase, input logic en_now);
    logic hit;
    hit = 1'b0;
    if (!phase && !en_now) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Edge write: enable rising while the phase is low.
  function automatic logic edge_write(input logic phase, input logic en_now,
                                      input logic en_before);
    logic hit;
    hit = 1'b0;
    if (!phase && !en_before && en_now) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Read one word out of both banks.
  function automatic word_t fetch(input addr_t a);
    word_t w;
    w = '0;
    for (int b = 0; b < BITS; b++) begin
      w[b] = bank[b][a];
    end
    return w;
  endfunction

  // Live word while the phase is high, slave word while it is low.
  function automatic word_t pick_word(input logic phase, input word_t live, input word_t held);
    word_t w;
    if (phase) begin
      w = live;
    end else begin
      w = held;
    end
    return w;
  endfunction

  // A closed gate drives low so that ports can be wire-ORed.
  function automatic word_t gate_word(input logic allow_n, input word_t data);
    word_t w;
    w = '0;
    if (!allow_n) begin
      w = data;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Phase tracking.
  // High in the half period that follows a rising edge.

  always_comb begin
    next_phase_high = ~phase_high;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_high <= 1'b0;
    end else begin
      phase_high <= next_phase_high;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable history for the edge-write path.
  // Holds the enables seen at the previous edge.

  always_comb begin
    next_enable_prev = wr.bit_write_n;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_prev <= '1;
    end else begin
      enable_prev <= next_enable_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write selection.
  // A bit writes on a low enable, or on a rising one, in the low phase.

  always_comb begin
    word_hit = decode_word(wr.addr);
  end

  always_comb begin
    level_strobe = '0;
    for (int b = 0; b < BITS; b++) begin
      level_strobe[b] = level_write(phase_high, wr.bit_write_n[b]);
    end
  end

  always_comb begin
    edge_strobe = '0;
    for (int b = 0; b < BITS; b++) begin
      edge_strobe[b] = edge_write(phase_high, wr.bit_write_n[b], enable_prev[b]);
    end
  end

  always_comb begin
    write_strobe = level_strobe | edge_strobe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage banks.
  // Both banks load their next image on every edge.

  always_comb begin
    for (int b = 0; b < BITS; b++) begin
      next_bank[b] = bank[b];
      for (int w = 0; w < WORDS; w++) begin
        if (write_strobe[b] && word_hit[w]) begin
          next_bank[b][w] = wr.data[b];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < BITS; b++) begin
        bank[b] <= '0;
      end
    end else begin
      for (int b = 0; b < BITS; b++) begin
        bank[b] <= next_bank[b];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture control.
  // Slaves load at the end of the high phase.

  always_comb begin
    capture = phase_high;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port zero.
  // Live word while high, slave word while low.

  always_comb begin
    live_zero = fetch(rd_zero.addr);
  end

  always_comb begin
    next_slave_zero = slave_zero;
    if (capture) begin
      next_slave_zero = live_zero;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slave_zero <= STORE_RESET;
    end else begin
      slave_zero <= next_slave_zero;
    end
  end

  always_comb begin
    held_zero = pick_word(phase_high, live_zero, slave_zero);
  end

  always_comb begin
    gated_zero = gate_word(rd_zero.read_gate_allow_n, held_zero);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port one.
  // Live word while high, slave word while low.

  always_comb begin
    live_one = fetch(rd_one.addr);
  end

  always_comb begin
    next_slave_one = slave_one;
    if (capture) begin
      next_slave_one = live_one;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slave_one <= STORE_RESET;
    end else begin
      slave_one <= next_slave_one;
    end
  end

  always_comb begin
    held_one = pick_word(phase_high, live_one, slave_one);
  end

  always_comb begin
    gated_one = gate_word(rd_one.read_gate_allow_n, held_one);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stages.
  // Gating is combinational so that it acts at any point in the cycle.

  always_comb begin
    read_port_zero_out = gated_zero;
  end

  always_comb begin
    read_port_one_out = gated_one;
  end

endmodule

`default_nettype wire

/* File: sim/port_driver.sv */
// Random request source.
`timescale 1ns/1ps
`default_nettype none
module port_driver import regfile_pkg::*; (
  input wire logic       clk, rst,
  output var write_req_s wr,
  output var read_req_s  rd_zero, rd_one);
  int   seed = 32'hC03F6B35;
  int   n = 0;
  logic ph;
  initial {wr, rd_zero, rd_one} = 15'h0300;
  // Inputs change only at the start of a low phase, so blocked enables stay high.
  always @(posedge clk) begin
    if (ph && !rst) begin
      #1;
      case (n)
        0: {wr, rd_zero, rd_one} = 15'h58AA;
        1: {wr, rd_zero, rd_one} = 15'h56AB;
        2: {wr, rd_zero, rd_one} = 15'h0F11;
        default: {wr, rd_zero, rd_one} = 15'($random(seed));
      endcase
      n++;
    end
    ph = !rst && !ph;
  end
endmodule
`default_nettype wire

/* File: sim/rf_gate_checker.sv */
// Concurrent checks on the ports of the multiport register file.
`timescale 1ns/1ps
`default_nettype none
module rf_gate_checker
  import regfile_pkg::*;
(
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst,
  // Write port.
  input wire write_req_s wr,
  // Read ports.
  input wire read_req_s  rd_zero,
  input wire read_req_s  rd_one,
  input wire word_t      read_port_zero_out,
  input wire word_t      read_port_one_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Mirror of the phase: high in the half period after a rising edge.
  logic ph;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 1'b0;
    end else begin
      ph <= ~ph;
    end
  end

  a_gate_zero: assert property (
    rd_zero.read_gate_allow_n |-> read_port_zero_out == 2'h0)
    else $error("port zero drives while its gate is closed");
  a_gate_one: assert property (
    rd_one.read_gate_allow_n |-> read_port_one_out == 2'h0)
    else $error("port one drives while its gate is closed");
  a_hold_zero_low: assert property (
    !ph && !rd_zero.read_gate_allow_n && $past(rd_zero.read_gate_allow_n) == 1'b0
    |-> read_port_zero_out == $past(read_port_zero_out))
    else $error("port zero changed in the low phase");
  a_hold_one_low: assert property (
    !ph && !rd_one.read_gate_allow_n && $past(rd_one.read_gate_allow_n) == 1'b0
    |-> read_port_one_out == $past(read_port_one_out))
    else $error("port one changed in the low phase");
  a_write_seen_zero: assert property (
    !ph && !wr.bit_write_n[0]
    |=> rd_zero.read_gate_allow_n || rd_zero.addr != $past(wr.addr)
        || read_port_zero_out[0] == $past(wr.data[0]))
    else $error("level write of bit zero not seen");
  a_write_seen_one: assert property (
    !ph && !wr.bit_write_n[1]
    |=> rd_one.read_gate_allow_n || rd_one.addr != $past(wr.addr)
        || read_port_one_out[1] == $past(wr.data[1]))
    else $error("level write of bit one not seen");
  a_edge_write_seen: assert property (
    !ph && $past(wr.bit_write_n[0]) == 1'b0 && wr.bit_write_n[0]
    |=> rd_zero.read_gate_allow_n || rd_zero.addr != $past(wr.addr)
        || read_port_zero_out[0] == $past(wr.data[0]))
    else $error("enable edge write of bit zero not seen");

  c_level_write: cover property (!ph && wr.bit_write_n == 2'h0);
  c_edge_write: cover property (!ph && $past(wr.bit_write_n) == 2'h0 && wr.bit_write_n == 2'h3);
  c_same_word: cover property (ph && rd_zero.addr == rd_one.addr
                               && !rd_zero.read_gate_allow_n && !rd_one.read_gate_allow_n);
endmodule
bind three_port_reg_file rf_gate_checker rf_gate_checker_i (
  .clk                (clk),
  .rst                (rst),
  .wr                 (wr),
  .rd_zero            (rd_zero),
  .rd_one             (rd_one),
  .read_port_zero_out (read_port_zero_out),
  .read_port_one_out  (read_port_one_out)
);
`default_nettype wire

/* File: sim/three_port_reg_file_tb.sv */
// Random bench.
`timescale 1ns/1ps
`default_nettype none
module three_port_reg_file_tb import regfile_pkg::*;;
  logic       clk = 0, rst = 1, ph;
  write_req_s wr;
  read_req_s  rd_zero, rd_one;
  word_t      read_port_zero_out, read_port_one_out, sz, so, prev, w, mem [WORDS] = '{default: 2'h0};
  int         err_count = 0, n_compared = 0, cyc = 0;
  port_driver port_driver_i (
    .clk     (clk),
    .rst     (rst),
    .wr      (wr),
    .rd_zero (rd_zero),
    .rd_one  (rd_one)
  );
  three_port_reg_file three_port_reg_file_i (
    .clk                (clk),
    .rst                (rst),
    .wr                 (wr),
    .rd_zero            (rd_zero),
    .rd_one             (rd_one),
    .read_port_zero_out (read_port_zero_out),
    .read_port_one_out  (read_port_one_out)
  );
  task check(word_t s, e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("%0d wrong of %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function word_t want(read_req_s r, word_t v);
    return r.read_gate_allow_n ? 2'h0 : ph ? mem[r.addr] : v;
  endfunction
  initial forever #10 clk = !clk;
  initial begin #201 rst = 0; #30000 stop_test(); end
  always @(posedge clk) begin
    if (++cyc == 2000) begin err_count++; stop_test(); end
    if (ph) begin sz = mem[rd_zero.addr]; so = mem[rd_one.addr]; end
    else if (!rst) begin
      w = ~(wr.bit_write_n & prev);
      mem[wr.addr] = mem[wr.addr] & ~w | wr.data & w;
    end
    ph = !rst && !ph;
    prev = wr.bit_write_n;
  end
  always @(negedge clk) if (!rst) begin
    check(read_port_zero_out, want(rd_zero, sz));
    check(read_port_one_out, want(rd_one, so));
  end
endmodule
`default_nettype wire
